//--- src/cpu_flow_control.sv
// Program counter, call stack and data stack control of an 8-bit core.
// Assumes one decoded command per cmd_valid while busy is low, and a
// data RAM that returns read data one cycle after it samples re.
//
// Behaviour
// [R1] Program counter is 14 bits wide, reaching 16 Kbytes of program.
// [R2] Reset clears the program counter to 0x0000.
// [R3] Normal steps advance only the low 8 counter bits.
// [R4] Upper six bits advance only on the page advance command.
// [R5] Low byte wraps from 0xff to 0x00 without carry upward.
// [R6] Interrupt acknowledge and call push two bytes: return address and flags.
// [R7] Counter and flags come back together only on interrupt return.
// [R8] No direct counter access; saved bytes live in RAM from 0x00.
// [R9] Reset clears the call stack pointer; call stack grows upward.
// [R10] Call stack pointer loads from the accumulator on its command.
// [R11] Acknowledge disables interrupts, writes first byte, bumps, writes second, bumps.
// [R12] Interrupt return pops second then first byte, then enables interrupts.
// [R13] Call stores address and flags and adds two to the pointer.
// [R14] Return restores the address only, keeps flags, subtracts two.
// [R15] Push pre-decrements the data stack pointer, then writes.
// [R16] Pop reads at the data stack pointer, then post-increments.
// [R17] Reset clears data stack pointer; push at zero writes 0xff.
// [R18] Swap exchanges the accumulator with the data stack pointer.
// [R19] Firmware should keep the data stack at or below 0xd8.
// [R20] Data mode takes the operand from the second instruction byte.
// [R21] Direct mode reads RAM at the one-byte instruction address.
// [R22] Auxiliary register acts as second accumulator and index.
// [R23] Indexed mode addresses RAM at constant plus auxiliary register.
// [R24] Both stack pointers are 8 bits and wrap modulo 256.
`timescale 1ns/10ps
module cpu_flow_control (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // Command from the decoder
  input  wire logic                cmd_valid,
  input  wire flow_pkg::flow_cmd_t cmd,
  input  wire logic                carry_in,
  input  wire logic                zero_in,
  // Data RAM
  output flow_pkg::ram_req_t       ram_req,
  input  wire logic [7:0]          ram_rdata,
  // Core state
  output logic      [13:0]         pc,
  output logic      [7:0]          call_stack_pointer,
  output logic      [7:0]          data_stack_pointer,
  output logic      [7:0]          aux,
  output logic                     carry,
  output logic                     zero,
  output logic                     int_enable,
  // Operand result
  output logic      [7:0]          result,
  output logic                     result_valid,
  output logic                     busy
);

  // ============================================================
  // State and helpers
  flow_pkg::flow_state_t st_r;
  flow_pkg::flow_state_t st_nxt;
  logic [13:0]           pc_step;
  logic [13:0]           pc_page;
  logic [7:0]            operand_addr;
  logic [7:0]            saved_hi;
  logic                  cmd_taken;

  // Everything passes as arguments, so assertions see sampled values
  function automatic logic starts(input logic taken, input flow_pkg::flow_op_t cur,
                                  input flow_pkg::flow_op_t op);
    return taken && cur == op;
  endfunction

  assign cmd_taken = cmd_valid && st_r.seq == flow_pkg::st_idle;

  // [R1] Fourteen-bit counter
  pc_stepper u_pc_stepper (
    .pc      (st_r.pc),
    .pc_step (pc_step),
    .pc_page (pc_page)
  );

  operand_address u_operand_address (
    .mode    (cmd.mode),
    .operand (cmd.operand),
    .aux     (st_r.aux),
    .addr    (operand_addr)
  );

  // ============================================================
  // Second saved byte
  // [R6] Flags beside page
  always_comb begin
    saved_hi = flow_pkg::BYTE_ZERO;
    saved_hi[flow_pkg::SAVED_PAGE_MSB:0] = st_r.pc[13:8];
    saved_hi[flow_pkg::SAVED_CARRY_BIT] = st_r.carry;
    saved_hi[flow_pkg::SAVED_ZERO_BIT] = st_r.zero;
  end

  // ============================================================
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.ram.we = 1'b0;
    st_nxt.ram.re = 1'b0;
    st_nxt.result_valid = 1'b0;
    unique case (st_r.seq)
      flow_pkg::st_idle: begin
        if (cmd_valid) begin
          unique case (cmd.op)
            // [R3] Sequential step
            flow_pkg::step_op: st_nxt.pc = pc_step;
            // [R4] Page advance
            flow_pkg::page_advance_op: st_nxt.pc = pc_page;
            // [R11] First byte out
            flow_pkg::call_op, flow_pkg::irq_ack_op: begin
              st_nxt.int_en = (cmd.op == flow_pkg::irq_ack_op) ? 1'b0 : st_r.int_en;
              st_nxt.carry = carry_in;
              st_nxt.zero = zero_in;
              st_nxt.target = cmd.target;
              st_nxt.ram.we = 1'b1;
              st_nxt.ram.addr = st_r.csp;
              st_nxt.ram.wdata = st_r.pc[7:0];
              st_nxt.csp = 8'(st_r.csp + flow_pkg::PTR_STEP);
              st_nxt.seq = flow_pkg::st_save_hi;
            end
            // [R12] Pop second byte
            flow_pkg::ret_op, flow_pkg::interrupt_return_op: begin
              st_nxt.is_interrupt_return_op = (cmd.op == flow_pkg::interrupt_return_op);
              st_nxt.csp = 8'(st_r.csp - flow_pkg::PTR_STEP);
              st_nxt.ram.re = 1'b1;
              st_nxt.ram.addr = 8'(st_r.csp - flow_pkg::PTR_STEP);
              st_nxt.seq = flow_pkg::st_rest_lo;
            end
            // [R10] Pointer from accumulator
            flow_pkg::load_call_stack_pointer_op: st_nxt.csp = cmd.operand;
            // [R15] Pre-decrement then write
            flow_pkg::push_op: begin
              st_nxt.dsp = 8'(st_r.dsp - flow_pkg::PTR_STEP);
              st_nxt.ram.we = 1'b1;
              st_nxt.ram.addr = 8'(st_r.dsp - flow_pkg::PTR_STEP);
              st_nxt.ram.wdata = cmd.operand;
            end
            // [R16] Read then post-increment
            flow_pkg::pop_op: begin
              st_nxt.dsp = 8'(st_r.dsp + flow_pkg::PTR_STEP);
              st_nxt.ram.re = 1'b1;
              st_nxt.ram.addr = st_r.dsp;
              st_nxt.seq = flow_pkg::st_read_issue;
            end
            // [R18] Exchange with accumulator
            flow_pkg::swap_dsp_op: begin
              st_nxt.dsp = cmd.operand;
              st_nxt.result = st_r.dsp;
              st_nxt.result_valid = 1'b1;
            end
            // [R22] Second accumulator
            flow_pkg::load_aux_op: st_nxt.aux = cmd.operand;
            flow_pkg::fetch_op: begin
              if (cmd.mode == flow_pkg::mode_data) begin
                // [R20] Immediate operand
                st_nxt.result = cmd.operand;
                st_nxt.result_valid = 1'b1;
              end else begin
                // [R21] RAM operand
                st_nxt.ram.re = 1'b1;
                st_nxt.ram.addr = operand_addr;
                st_nxt.seq = flow_pkg::st_read_issue;
              end
            end
            default: ;
          endcase
        end
      end
      // [R13] Second byte, plus two overall
      flow_pkg::st_save_hi: begin
        st_nxt.ram.we = 1'b1;
        st_nxt.ram.addr = st_r.csp;
        st_nxt.ram.wdata = saved_hi;
        st_nxt.csp = 8'(st_r.csp + flow_pkg::PTR_STEP);
        st_nxt.pc = st_r.target;
        st_nxt.seq = flow_pkg::st_idle;
      end
      // [R12] Pop first byte
      flow_pkg::st_rest_lo: begin
        st_nxt.csp = 8'(st_r.csp - flow_pkg::PTR_STEP);
        st_nxt.ram.re = 1'b1;
        st_nxt.ram.addr = 8'(st_r.csp - flow_pkg::PTR_STEP);
        st_nxt.seq = flow_pkg::st_rest_cap;
      end
      flow_pkg::st_rest_cap: begin
        st_nxt.saved_hi = ram_rdata;
        st_nxt.seq = flow_pkg::st_rest_done;
      end
      // [R7] Flags only on interrupt return
      flow_pkg::st_rest_done: begin
        st_nxt.pc = {st_r.saved_hi[flow_pkg::SAVED_PAGE_MSB:0], ram_rdata};
        if (st_r.is_interrupt_return_op) begin
          st_nxt.carry = st_r.saved_hi[flow_pkg::SAVED_CARRY_BIT];
          st_nxt.zero = st_r.saved_hi[flow_pkg::SAVED_ZERO_BIT];
          st_nxt.int_en = 1'b1;
        end
        st_nxt.seq = flow_pkg::st_idle;
      end
      flow_pkg::st_read_issue: st_nxt.seq = flow_pkg::st_read_cap;
      flow_pkg::st_read_cap: begin
        st_nxt.result = ram_rdata;
        st_nxt.result_valid = 1'b1;
        st_nxt.seq = flow_pkg::st_idle;
      end
      default: st_nxt.seq = flow_pkg::st_idle;
    endcase
    st_nxt.busy = (st_nxt.seq != flow_pkg::st_idle);
  end

  // [R2] Synchronous clear
  // [R9] Call stack from zero
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r <= flow_pkg::STATE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs, all from the state register
  // [R8] Counter visible, never writable
  assign pc = st_r.pc;
  assign call_stack_pointer = st_r.csp;
  assign data_stack_pointer = st_r.dsp;
  assign aux = st_r.aux;
  assign carry = st_r.carry;
  assign zero = st_r.zero;
  assign int_enable = st_r.int_en;
  assign result = st_r.result;
  assign result_valid = st_r.result_valid;
  assign busy = st_r.busy;
  assign ram_req = st_r.ram;

  // ============================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence save_pair;
    st_r.ram.we && st_r.ram.addr == 8'($past(st_r.csp))
      ##1 st_r.ram.we && st_r.ram.addr == 8'($past(st_r.csp, 2) + 8'h01);
  endsequence

  sequence restore_quad;
    st_r.ram.re && st_r.ram.addr == 8'($past(st_r.csp) - 8'h01)
      ##1 st_r.ram.re && st_r.ram.addr == 8'($past(st_r.csp, 2) - 8'h02)
      ##2 st_r.csp == 8'($past(st_r.csp, 4) - 8'h02);
  endsequence

  chk_reset_clear: assert property ( // [R2]
    disable iff (1'b0) !reset_n |=> st_r.pc == 14'h0000 && !busy)
    else $error("pc not cleared by reset");
  chk_reset_ptrs: assert property ( // [R9]
    disable iff (1'b0) !reset_n |=> st_r.csp == 8'h00 && st_r.dsp == 8'h00)
    else $error("stack pointers not cleared by reset");
  chk_step_low: assert property ( // [R3]
    starts(cmd_taken, cmd.op, flow_pkg::step_op)
      |=> pc[13:8] == $past(pc[13:8])
      && pc[7:0] == 8'($past(pc[7:0]) + 8'h01))
    else $error("step changed page or missed low byte");
  chk_step_wrap: assert property ( // [R5]
    starts(cmd_taken, cmd.op, flow_pkg::step_op) && pc[7:0] == 8'hff
      |=> pc[7:0] == 8'h00
      && $stable(pc[13:8]))
    else $error("low byte wrap carried into page");
  chk_page_adv: assert property ( // [R4]
    starts(cmd_taken, cmd.op, flow_pkg::page_advance_op)
      |=> pc[13:8] == 6'($past(pc[13:8]) + 6'h01))
    else $error("page advance missed");
  chk_call_save: assert property ( // [R13]
    starts(cmd_taken, cmd.op, flow_pkg::call_op)
      |=> save_pair ##0 pc == $past(cmd.target, 2)
      && st_r.csp == 8'($past(st_r.csp, 2) + 8'h02))
    else $error("call did not save two bytes");
  chk_irq_ack_seq: assert property ( // [R11]
    starts(cmd_taken, cmd.op, flow_pkg::irq_ack_op)
      |=> !int_enable ##0 save_pair)
    else $error("interrupt acknowledge sequence wrong");
  chk_saved_bytes: assert property ( // [R6]
    starts(cmd_taken, cmd.op, flow_pkg::call_op)
      |=> ram_req.wdata == $past(pc[7:0])
      ##1 ram_req.wdata[5:0] == $past(pc[13:8], 2)
      && ram_req.wdata[7] == $past(carry_in, 2)
      && ram_req.wdata[6] == $past(zero_in, 2))
    else $error("saved bytes wrong");
  chk_interrupt_return_op_restore: assert property ( // [R12]
    starts(cmd_taken, cmd.op, flow_pkg::interrupt_return_op)
      |=> restore_quad
      ##0 int_enable && ($rose(int_enable) || $past(int_enable, 4)))
    else $error("interrupt return sequence wrong");
  chk_interrupt_return_op_flags: assert property ( // [R7]
    starts(cmd_taken, cmd.op, flow_pkg::interrupt_return_op)
      |=> ##2
      (st_r.seq == flow_pkg::st_rest_done ##1 carry == $past(st_r.saved_hi[7])
      && zero == $past(st_r.saved_hi[6])))
    else $error("flags not restored on interrupt return");
  chk_ret_keeps: assert property ( // [R14]
    starts(cmd_taken, cmd.op, flow_pkg::ret_op)
      |=> restore_quad ##0 carry == $past(carry, 4)
      && zero == $past(zero, 4) && int_enable == $past(int_enable, 4))
    else $error("return touched flags");
  chk_load_csp: assert property ( // [R10]
    starts(cmd_taken, cmd.op, flow_pkg::load_call_stack_pointer_op)
      |=> call_stack_pointer == $past(cmd.operand))
    else $error("call stack pointer not loaded");
  chk_push_predec: assert property ( // [R15]
    starts(cmd_taken, cmd.op, flow_pkg::push_op)
      |=> ram_req.we && ram_req.addr == 8'($past(st_r.dsp) - 8'h01)
      && st_r.dsp == ram_req.addr && ram_req.wdata == $past(cmd.operand))
    else $error("push not pre-decremented");
  chk_push_top: assert property ( // [R17]
    starts(cmd_taken, cmd.op, flow_pkg::push_op) && st_r.dsp == 8'h00
      |=> ram_req.addr == flow_pkg::RAM_TOP)
    else $error("push at zero missed top of RAM");
  chk_pop_postinc: assert property ( // [R16]
    starts(cmd_taken, cmd.op, flow_pkg::pop_op)
      |=> ram_req.re && ram_req.addr == $past(st_r.dsp)
      && st_r.dsp == 8'(ram_req.addr + 8'h01) ##2 result_valid)
    else $error("pop not post-incremented");
  chk_swap_dsp: assert property ( // [R18]
    starts(cmd_taken, cmd.op, flow_pkg::swap_dsp_op)
      |=> result == $past(st_r.dsp)
      && st_r.dsp == $past(cmd.operand) && result_valid)
    else $error("swap wrong");
  chk_data_mode: assert property ( // [R20]
    starts(cmd_taken, cmd.op, flow_pkg::fetch_op) && cmd.mode == flow_pkg::mode_data
      |=> result_valid && result == $past(cmd.operand) && !ram_req.re)
    else $error("data mode operand wrong");
  chk_direct_mode: assert property ( // [R21]
    starts(cmd_taken, cmd.op, flow_pkg::fetch_op) && cmd.mode == flow_pkg::mode_direct
      |=> ram_req.re && ram_req.addr == $past(cmd.operand) ##2 result_valid)
    else $error("direct mode address wrong");
  chk_indexed_mode: assert property ( // [R23]
    starts(cmd_taken, cmd.op, flow_pkg::fetch_op) && cmd.mode == flow_pkg::mode_indexed
      |=> ram_req.addr == 8'($past(cmd.operand) + $past(aux)))
    else $error("indexed address wrong");
  chk_aux_load: assert property ( // [R22]
    starts(cmd_taken, cmd.op, flow_pkg::load_aux_op)
      |=> aux == $past(cmd.operand))
    else $error("auxiliary register not loaded");
  chk_csp_wrap: assert property ( // [R24]
    starts(cmd_taken, cmd.op, flow_pkg::call_op) && st_r.csp == 8'hff
      |=> st_r.csp == 8'h00)
    else $error("call stack pointer did not wrap");

endmodule

//--- src/flow_pkg.sv
// Shared types and constants for the program-flow and stack-pointer core.
// Assumes a data RAM with one-cycle synchronous read latency.
package flow_pkg;

  // ============================================================
  // Widths and reset values
  localparam int          PC_W       = 14;
  localparam int          BYTE_W     = 8;
  localparam int          PAGE_W     = 6;
  localparam logic [13:0] PC_RESET   = 14'h0000;
  localparam logic [7:0]  CSP_RESET  = 8'h00;
  localparam logic [7:0]  DSP_RESET  = 8'h00;
  localparam logic [7:0]  AUX_RESET  = 8'h00;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic        INT_RESET  = 1'b0;
  localparam logic [7:0]  PTR_STEP   = 8'h01;
  localparam logic [7:0]  LOW_STEP   = 8'h01;
  localparam logic [5:0]  PAGE_STEP  = 6'h01;
  localparam logic [7:0]  RAM_TOP    = 8'hff;

  // ============================================================
  // Second saved byte: flags above the page bits
  localparam int SAVED_CARRY_BIT = 7;
  localparam int SAVED_ZERO_BIT  = 6;
  localparam int SAVED_PAGE_MSB  = 5;

  // ============================================================
  // Commands and modes
  typedef enum logic [3:0] {
    step_op                    = 4'h0,
    page_advance_op            = 4'h1,
    call_op                    = 4'h2,
    irq_ack_op                 = 4'h3,
    ret_op                     = 4'h4,
    interrupt_return_op        = 4'h5,
    load_call_stack_pointer_op = 4'h6,
    push_op                    = 4'h7,
    pop_op                     = 4'h8,
    swap_dsp_op                = 4'h9,
    load_aux_op                = 4'ha,
    fetch_op                   = 4'hb
  } flow_op_t;

  typedef enum logic [1:0] {
    mode_data     = 2'h0,
    mode_direct   = 2'h1,
    mode_indexed  = 2'h2
  } addr_mode_t;

  typedef enum logic [2:0] {
    st_idle       = 3'h0,
    st_save_hi    = 3'h1,
    st_rest_lo    = 3'h2,
    st_rest_cap   = 3'h3,
    st_rest_done  = 3'h4,
    st_read_issue = 3'h5,
    st_read_cap   = 3'h6
  } seq_state_t;

  // ============================================================
  // Carriers
  typedef struct packed {
    flow_op_t    op;
    addr_mode_t  mode;
    logic [7:0]  operand;
    logic [13:0] target;
  } flow_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } ram_req_t;

  typedef struct packed {
    seq_state_t  seq;
    logic [13:0] pc;
    logic [13:0] target;
    logic [7:0]  csp;
    logic [7:0]  dsp;
    logic [7:0]  aux;
    logic [7:0]  saved_hi;
    logic [7:0]  result;
    logic        carry;
    logic        zero;
    logic        int_en;
    logic        is_interrupt_return_op;
    logic        result_valid;
    logic        busy;
    ram_req_t    ram;
  } flow_state_t;

  localparam flow_state_t STATE_RESET = '{
    seq: st_idle, pc: PC_RESET, target: PC_RESET, csp: CSP_RESET,
    dsp: DSP_RESET, aux: AUX_RESET, saved_hi: BYTE_ZERO, result: BYTE_ZERO,
    carry: 1'b0, zero: 1'b0, int_en: INT_RESET, is_interrupt_return_op: 1'b0,
    result_valid: 1'b0, busy: 1'b0,
    ram: '{addr: BYTE_ZERO, wdata: BYTE_ZERO, we: 1'b0, re: 1'b0}};

endpackage

//--- src/operand_address.sv
// Data RAM operand address for direct and indexed modes.
// Purely combinational; data mode needs no address.
`timescale 1ns/10ps
module operand_address (
  // Decoded operand
  input  wire flow_pkg::addr_mode_t mode,
  input  wire logic [7:0]           operand,
  input  wire logic [7:0]           aux,
  // Address
  output logic      [7:0]           addr
);

  // ============================================================
  // Address forming
  always_comb begin
    addr = operand;
    // [R23] Base plus index
    if (mode == flow_pkg::mode_indexed) begin
      addr = 8'(operand + aux);
    end
  end

endmodule

//--- src/pc_stepper.sv
// Next program counter for a plain step and for a page advance.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module pc_stepper (
  // Current counter
  input  wire logic [13:0] pc,
  // Candidates
  output logic      [13:0] pc_step,
  output logic      [13:0] pc_page
);

  // ============================================================
  // Low byte wraps inside its page
  // [R3] Low byte only
  // [R5] No carry out
  assign pc_step = {pc[13:8], 8'(pc[7:0] + flow_pkg::LOW_STEP)};

  // [R4] Page bits advance
  assign pc_page = {6'(pc[13:8] + flow_pkg::PAGE_STEP),
                    8'(pc[7:0] + flow_pkg::LOW_STEP)};

endmodule

//--- testbench/flow_ram_model.sv
// Behavioural data RAM facing the core's request port.
// Assumes registered requests; read data answers one cycle after re.
`timescale 1ns/10ps
module flow_ram_model (
  // Clock
  input  wire logic               clk_sys,
  // Request and answer
  input  wire flow_pkg::ram_req_t ram_req,
  output logic [7:0]              ram_rdata
);
  logic [7:0] mem_r [256];

  initial begin
    ram_rdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem_r[i] = 8'h00;
    end
  end

  // ============================================================
  // Storage and read port
  always @(posedge clk_sys) begin
    if (ram_req.we === 1'b1) begin
      mem_r[ram_req.addr] <= ram_req.wdata;
    end
    // Stale data toggles so a late capture cannot pass
    if (ram_req.re === 1'b1) begin
      ram_rdata <= mem_r[ram_req.addr];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end
endmodule

//--- testbench/test_cpu_flow_control.sv
// Self-checking bench for the program-flow and stack core.
// Assumes the RAM model answers reads one cycle after re.
`timescale 1ns/10ps
module test_cpu_flow_control;
  // ============================================================
  // Design ports
  logic                clk_sys;
  logic                reset_n;
  logic                cmd_valid;
  flow_pkg::flow_cmd_t cmd;
  logic                carry_in;
  logic                zero_in;
  flow_pkg::ram_req_t  ram_req;
  logic [7:0]          ram_rdata;
  logic [13:0]         pc;
  logic [7:0]          call_stack_pointer;
  logic [7:0]          data_stack_pointer;
  logic [7:0]          aux;
  logic                carry;
  logic                zero;
  logic                int_enable;
  logic [7:0]          result;
  logic                result_valid;
  logic                busy;
  // Bench state
  int                  miscompares;
  int                  n_tests;
  int                  seed;
  logic [7:0]          exp_q [$];
  logic [7:0]          vals [4];
  logic [7:0]          base;
  logic [13:0]         tgt_r;
  logic                rc;
  logic                rz;

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  cpu_flow_control u_cpu_flow_control (
    .clk_sys            (clk_sys),
    .reset_n            (reset_n),
    .cmd_valid          (cmd_valid),
    .cmd                (cmd),
    .carry_in           (carry_in),
    .zero_in            (zero_in),
    .ram_req            (ram_req),
    .ram_rdata          (ram_rdata),
    .pc                 (pc),
    .call_stack_pointer (call_stack_pointer),
    .data_stack_pointer (data_stack_pointer),
    .aux                (aux),
    .carry              (carry),
    .zero               (zero),
    .int_enable         (int_enable),
    .result             (result),
    .result_valid       (result_valid),
    .busy               (busy)
  );

  flow_ram_model u_flow_ram_model (
    .clk_sys   (clk_sys),
    .ram_req   (ram_req),
    .ram_rdata (ram_rdata)
  );

  // ============================================================
  // Compare and closing tasks
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk14(input logic [13:0] got, input logic [13:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t counter got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One command; returns at a falling edge once busy is low
  task automatic do_op(input flow_pkg::flow_op_t op, input logic [7:0] opd = 8'h00,
                       input flow_pkg::addr_mode_t md = flow_pkg::mode_data,
                       input logic [13:0] tgt = 14'h0000, input logic c = 1'b0, input logic z = 1'b0);
    int i;
    @(posedge clk_sys);
    cmd       <= '{op, md, opd, tgt};
    cmd_valid <= 1'b1;
    carry_in  <= c;
    zero_in   <= z;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      if (busy === 1'b0) break;
    end
    if (busy !== 1'b0) begin
      miscompares++;
      $display("MISMATCH t=%0t busy stuck", $time);
    end
  endtask

  // ============================================================
  // Result monitor: oldest note against each pulse
  always @(negedge clk_sys) begin
    if (result_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
        $display("MISMATCH t=%0t result without note", $time);
      end else begin
        chk8(result, exp_q.pop_front());
      end
    end
  end

  initial begin
    #100000;
    miscompares++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end

  // ============================================================
  // Main sequence
  initial begin
    seed = 51;
    miscompares = 0;
    n_tests = 0;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    carry_in = 1'b0;
    zero_in = 1'b0;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk14(pc, 14'h0000);
    chk8(call_stack_pointer, 8'h00);
    chk8(data_stack_pointer, 8'h00);
    do_op(flow_pkg::call_op, 8'h00, flow_pkg::mode_data, 14'h12fe, 1'b1, 1'b0);
    chk14(pc, 14'h12fe);
    chk8(call_stack_pointer, 8'h02);
    do_op(flow_pkg::step_op);
    chk14(pc, 14'h12ff);
    do_op(flow_pkg::step_op);
    chk14(pc, 14'h1200);
    do_op(flow_pkg::page_advance_op);
    chk14(pc, 14'h1301);
    rc = 1'($random(seed));
    rz = 1'($random(seed));
    do_op(flow_pkg::irq_ack_op, 8'h00, flow_pkg::mode_data, 14'h0040, rc, rz);
    chk8(call_stack_pointer, 8'h04);
    chk8({5'h00, int_enable, carry, zero}, {6'h00, rc, rz});
    do_op(flow_pkg::step_op);
    do_op(flow_pkg::call_op, 8'h00, flow_pkg::mode_data, 14'h0200, !rc, !rz);
    do_op(flow_pkg::ret_op);
    chk14(pc, 14'h0041);
    chk8({5'h00, int_enable, carry, zero}, {6'h00, !rc, !rz});
    chk8(call_stack_pointer, 8'h04);
    do_op(flow_pkg::interrupt_return_op);
    chk14(pc, 14'h1301);
    chk8({5'h00, int_enable, carry, zero}, {6'h01, rc, rz});
    chk8(call_stack_pointer, 8'h02);
    // Acknowledge again with interrupts on, so the disable shows
    do_op(flow_pkg::irq_ack_op, 8'h00, flow_pkg::mode_data, 14'h0048, rz, rc);
    chk8({5'h00, int_enable, carry, zero}, {6'h00, rz, rc});
    do_op(flow_pkg::interrupt_return_op);
    chk14(pc, 14'h1301);
    chk8({5'h00, int_enable, carry, zero}, {6'h01, rz, rc});
    do_op(flow_pkg::load_call_stack_pointer_op, 8'hff);
    chk8(call_stack_pointer, 8'hff);
    tgt_r = 14'($random(seed));
    do_op(flow_pkg::call_op, 8'h00, flow_pkg::mode_data, tgt_r);
    chk14(pc, tgt_r);
    chk8(call_stack_pointer, 8'h01);
    do_op(flow_pkg::ret_op);
    chk14(pc, 14'h1301);
    chk8(call_stack_pointer, 8'hff);
    do_op(flow_pkg::push_op, 8'h5a);
    chk8(data_stack_pointer, 8'hff);
    do_op(flow_pkg::push_op, 8'ha5);
    chk8(data_stack_pointer, 8'hfe);
    exp_q.push_back(8'ha5);
    do_op(flow_pkg::pop_op);
    chk8(data_stack_pointer, 8'hff);
    exp_q.push_back(8'h5a);
    do_op(flow_pkg::pop_op);
    chk8(data_stack_pointer, 8'h00);
    do_op(flow_pkg::load_aux_op, 8'h03);
    chk8(aux, 8'h03);
    exp_q.push_back(8'h77);
    do_op(flow_pkg::fetch_op, 8'h77, flow_pkg::mode_data);
    exp_q.push_back(8'h80);
    do_op(flow_pkg::fetch_op, 8'h01, flow_pkg::mode_direct);
    exp_q.push_back({rz, rc, 6'h13});
    do_op(flow_pkg::fetch_op, 8'h03, flow_pkg::mode_direct);
    exp_q.push_back(8'ha5);
    do_op(flow_pkg::fetch_op, 8'hfe, flow_pkg::mode_direct);
    exp_q.push_back(8'h5a);
    do_op(flow_pkg::fetch_op, 8'hfc, flow_pkg::mode_indexed);
    base = 8'h20 + 8'($unsigned($random(seed)) % 185);
    exp_q.push_back(8'h00);
    do_op(flow_pkg::swap_dsp_op, base);
    chk8(data_stack_pointer, base);
    for (int i = 0; i < 4; i++) begin
      vals[i] = 8'($random(seed));
      do_op(flow_pkg::push_op, vals[i]);
    end
    chk8(data_stack_pointer, base - 8'h04);
    for (int i = 3; i >= 0; i--) begin
      exp_q.push_back(vals[i]);
      do_op(flow_pkg::pop_op);
    end
    chk8(data_stack_pointer, base);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    chk14(pc, 14'h0000);
    chk8(data_stack_pointer, 8'h00);
    chk8(call_stack_pointer, 8'h00);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("MISMATCH t=%0t results missing", $time);
    end
    summarize();
  end
endmodule
